// ===== tdpe_pkg.sv
// Shared constants for the time-of-flight depth pixel engine.
// Assumes a 250 MHz core clock and a 32-bit AHB-Lite register bus.
package tdpe_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] TDPE_OFS_CTRL = 8'h00;
  localparam logic [7:0] TDPE_OFS_BIN = 8'h04;
  localparam logic [7:0] TDPE_OFS_SHIFT = 8'h08;
  localparam logic [7:0] TDPE_OFS_THRESH = 8'h0c;
  localparam logic [7:0] TDPE_OFS_OFFSET = 8'h10;
  localparam logic [7:0] TDPE_OFS_STATUS = 8'h14;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int TDPE_CTRL_TG = 0;
  localparam int TDPE_CTRL_ALT = 1;
  localparam int TDPE_CTRL_COMBINE = 2;
  localparam int TDPE_CTRL_SHIFT_EN = 3;
  localparam int TDPE_CTRL_FLAGS_AMB = 4;
  localparam int TDPE_CTRL_OFS_BYP = 5;
  localparam int TDPE_BIN_ROW = 0;
  localparam int TDPE_BIN_COL = 4;
  localparam int TDPE_BIN_RATIO = 8;
  localparam int TDPE_THR_SAT = 16;
  localparam int TDPE_OFS_SUPP = 16;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [5:0] TDPE_CTRL_RST = 6'h00;
  localparam logic [1:0] TDPE_RATIO_RST = 2'h2;
  localparam logic [11:0] TDPE_THR_RST = 12'h000;
  localparam logic [11:0] TDPE_PHOFS_RST = 12'h000;

  // ---------------------------------------------------------------
  // Widths, sizes and codes
  // ---------------------------------------------------------------
  localparam int TDPE_XY_W = 22;
  localparam int TDPE_CW = 24;
  localparam int TDPE_CORDIC_STAGES = 11;
  localparam int TDPE_COLS = 80;
  localparam int TDPE_PIXELS = 4800;
  localparam logic [11:0] TDPE_LEVEL_MAX = 12'hfff;
  localparam logic [11:0] TDPE_HALF_TURN = 12'h800;
  localparam logic [15:0] TDPE_ROUND_HALF = 16'h0800;
  localparam logic [11:0] TDPE_ATAN [0:10] = '{12'h200, 12'h12e, 12'h0a0, 12'h051, 12'h029, 12'h014,
                                                12'h00a, 12'h005, 12'h003, 12'h001, 12'h001};

  typedef enum logic [1:0] {
    TDPE_ST_NO_BASE = 2'b01,
    TDPE_ST_BASE_HELD = 2'b10
  } tdpe_state_t;

endpackage : tdpe_pkg

// ===== tdpe_cordic.sv
// Vectoring rotator: angle and magnitude of an I/Q vector, purely combinational.
// Assumes its caller registers both results.
`timescale 1ns/1ps
module tdpe_cordic (
  input wire logic signed [tdpe_pkg::TDPE_XY_W-1:0] vec_x, // In-phase component
  input wire logic signed [tdpe_pkg::TDPE_XY_W-1:0] vec_y, // Quadrature component
  output logic [11:0] angle, // Full turn over 4096 codes
  output logic [tdpe_pkg::TDPE_CW-1:0] magnitude // Vector length times rotator gain
);
  localparam int W = tdpe_pkg::TDPE_CW;
  localparam int N = tdpe_pkg::TDPE_CORDIC_STAGES;

  logic signed [W-1:0] xs [0:N];
  logic signed [W-1:0] ys [0:N];
  logic [11:0] zs [0:N];

  wire signed [W-1:0] x_in = W'(vec_x);
  wire signed [W-1:0] y_in = W'(vec_y);
  wire flip = vec_x[tdpe_pkg::TDPE_XY_W-1];

  // Left half plane is turned by half a turn first, so stages only cover +-90 degrees
  assign xs[0] = flip ? -x_in : x_in;
  assign ys[0] = flip ? -y_in : y_in;
  assign zs[0] = flip ? tdpe_pkg::TDPE_HALF_TURN : 12'h000;

  generate
    for (genvar k = 0; k < N; k++) begin : g_stage
      wire up = ~ys[k][W-1];
      assign xs[k+1] = up ? xs[k] + (ys[k] >>> k) : xs[k] - (ys[k] >>> k);
      assign ys[k+1] = up ? ys[k] - (xs[k] >>> k) : ys[k] + (xs[k] >>> k);
      // Modulo 4096 accumulation puts zero phase at code zero
      assign zs[k+1] = up ? zs[k] + tdpe_pkg::TDPE_ATAN[k] : zs[k] - tdpe_pkg::TDPE_ATAN[k];
    end
  endgenerate

  assign angle = zs[N];
  assign magnitude = W'(unsigned'(xs[N]));

endmodule : tdpe_cordic

// ===== tdpe_depth_engine.sv
// Depth pixel engine: binning, phase/amplitude, masking, offset, de-aliasing, packing.
// Assumes ADC samples arrive on the core clock; registers sit on an AHB-Lite slave.
`timescale 1ns/1ps
module tdpe_depth_engine (
  input wire logic clock, // Core clock, 250 MHz
  input wire logic arst_n, // Asynchronous reset
  input wire logic hsel, // AHB select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size, word only
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic hreadyout, // AHB slave ready
  output logic [31:0] hrdata, // AHB read data
  output logic hresp, // AHB response, always OKAY
  input wire logic in_valid, // ADC pixel strobe
  input wire logic signed [11:0] in_sample_i, // In-phase sample
  input wire logic signed [11:0] in_sample_q, // Quadrature sample
  input wire logic [11:0] in_level, // Non-modulating voltage code
  input wire logic in_frame_start, // First pixel of frame
  input wire logic in_row_end, // Last pixel of row
  input wire logic in_supp_frame, // Frame uses supplementary frequency
  output logic out_valid, // Output pixel strobe
  output logic [15:0] out_phase_word, // Flags over phase; combined 16-bit phase when combining
  output logic [15:0] out_amp_word, // Ambient over amplitude; flags over amplitude when combining with flags-to-ambient set
  output logic out_frame_start, // First output pixel of frame
  output logic timing_generator_run, // Timing generator enable
  output logic alternate_frame_enable // Alternate frame sequencing
);

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  logic [5:0] ctrl_reg;
  logic [1:0] row_exp_reg;
  logic [1:0] col_exp_reg;
  logic [1:0] ratio_reg;
  logic [2:0] shift_reg;
  logic [11:0] amp_thr_reg;
  logic [11:0] sat_thr_reg;
  logic [11:0] base_ofs_reg;
  logic [11:0] supp_ofs_reg;
  logic [1:0] fc_reg;
  tdpe_pkg::tdpe_state_t state_reg;
  tdpe_pkg::tdpe_state_t state_next;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;

  wire ahb_take = hsel & htrans[1] & hready;
  wire [7:0] rd_addr = haddr[7:0];
  wire [31:0] rd_data =
    (rd_addr == tdpe_pkg::TDPE_OFS_CTRL) ? {26'h0, ctrl_reg} :
    (rd_addr == tdpe_pkg::TDPE_OFS_BIN) ? {22'h0, ratio_reg, 2'h0, col_exp_reg, 2'h0, row_exp_reg} :
    (rd_addr == tdpe_pkg::TDPE_OFS_SHIFT) ? {29'h0, shift_reg} :
    (rd_addr == tdpe_pkg::TDPE_OFS_THRESH) ? {4'h0, sat_thr_reg, 4'h0, amp_thr_reg} :
    (rd_addr == tdpe_pkg::TDPE_OFS_OFFSET) ? {4'h0, supp_ofs_reg, 4'h0, base_ofs_reg} :
    (rd_addr == tdpe_pkg::TDPE_OFS_STATUS) ? {28'h0, state_reg == tdpe_pkg::TDPE_ST_BASE_HELD, 1'b0, fc_reg} :
    32'h0;

  wire wr_ctrl = wr_pend_reg & (wr_addr_reg == tdpe_pkg::TDPE_OFS_CTRL);
  wire wr_bin = wr_pend_reg & (wr_addr_reg == tdpe_pkg::TDPE_OFS_BIN);
  wire wr_shift = wr_pend_reg & (wr_addr_reg == tdpe_pkg::TDPE_OFS_SHIFT);
  wire wr_thr = wr_pend_reg & (wr_addr_reg == tdpe_pkg::TDPE_OFS_THRESH);
  wire wr_ofs = wr_pend_reg & (wr_addr_reg == tdpe_pkg::TDPE_OFS_OFFSET);

  wire combine = ctrl_reg[tdpe_pkg::TDPE_CTRL_COMBINE];
  wire shift_en = ctrl_reg[tdpe_pkg::TDPE_CTRL_SHIFT_EN];
  wire flags_to_amb = ctrl_reg[tdpe_pkg::TDPE_CTRL_FLAGS_AMB];
  wire ofs_bypass = ctrl_reg[tdpe_pkg::TDPE_CTRL_OFS_BYP];

  // Zero wait states: read data is fetched in the address phase
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_reg <= ahb_take & hwrite;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (ahb_take) begin
        wr_addr_reg <= rd_addr;
      end
      if (ahb_take & ~hwrite) begin
        hrdata <= rd_data;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= tdpe_pkg::TDPE_CTRL_RST;
      row_exp_reg <= 2'h0;
      col_exp_reg <= 2'h0;
      ratio_reg <= tdpe_pkg::TDPE_RATIO_RST;
      shift_reg <= 3'h0;
      amp_thr_reg <= tdpe_pkg::TDPE_THR_RST;
      sat_thr_reg <= tdpe_pkg::TDPE_THR_RST;
      base_ofs_reg <= tdpe_pkg::TDPE_PHOFS_RST;
      supp_ofs_reg <= tdpe_pkg::TDPE_PHOFS_RST;
    end else begin
      if (wr_ctrl) ctrl_reg <= hwdata[5:0];
      if (wr_bin) begin
        row_exp_reg <= hwdata[tdpe_pkg::TDPE_BIN_ROW +: 2];
        col_exp_reg <= hwdata[tdpe_pkg::TDPE_BIN_COL +: 2];
        ratio_reg <= hwdata[tdpe_pkg::TDPE_BIN_RATIO +: 2];
      end
      if (wr_shift) shift_reg <= hwdata[2:0];
      if (wr_thr) begin
        amp_thr_reg <= hwdata[11:0];
        sat_thr_reg <= hwdata[tdpe_pkg::TDPE_THR_SAT +: 12];
      end
      if (wr_ofs) begin
        base_ofs_reg <= hwdata[11:0];
        supp_ofs_reg <= hwdata[tdpe_pkg::TDPE_OFS_SUPP +: 12];
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      timing_generator_run <= 1'b0;
      alternate_frame_enable <= 1'b0;
    end else begin
      timing_generator_run <= ctrl_reg[tdpe_pkg::TDPE_CTRL_TG];
      alternate_frame_enable <= ctrl_reg[tdpe_pkg::TDPE_CTRL_ALT];
    end
  end

  // ---------------------------------------------------------------
  // Input scaling and binning
  // ---------------------------------------------------------------
  logic signed [25:0] acc_i_reg;
  logic signed [25:0] acc_q_reg;
  logic [17:0] acc_a_reg;
  logic [2:0] col_cnt_reg;
  logic [2:0] row_cnt_reg;
  logic [6:0] bcol_reg;
  logic first_pend_reg;
  logic signed [25:0] line_i [0:tdpe_pkg::TDPE_COLS-1];
  logic signed [25:0] line_q [0:tdpe_pkg::TDPE_COLS-1];
  logic [17:0] line_a [0:tdpe_pkg::TDPE_COLS-1];

  wire [2:0] shamt = shift_en ? shift_reg : 3'h0;
  wire signed [19:0] i_sh = 20'(in_sample_i) <<< shamt;
  wire signed [19:0] q_sh = 20'(in_sample_q) <<< shamt;
  wire [11:0] amb_in = tdpe_pkg::TDPE_LEVEL_MAX - in_level;

  wire [2:0] col_lim = 3'((4'h1 << col_exp_reg) - 4'h1);
  wire [2:0] row_lim = 3'((4'h1 << row_exp_reg) - 4'h1);
  wire [2:0] col_now = in_frame_start ? 3'h0 : col_cnt_reg;
  wire [2:0] row_now = in_frame_start ? 3'h0 : row_cnt_reg;
  wire [6:0] bcol_now = in_frame_start ? 7'h00 : bcol_reg;
  wire col_last = col_now == col_lim;
  wire row_last = row_now == row_lim;
  wire emit = in_valid & col_last & row_last;

  wire signed [25:0] grp_i = ((col_now == 3'h0) ? 26'sh0 : acc_i_reg) + 26'(i_sh);
  wire signed [25:0] grp_q = ((col_now == 3'h0) ? 26'sh0 : acc_q_reg) + 26'(q_sh);
  wire [17:0] grp_a = ((col_now == 3'h0) ? 18'h0 : acc_a_reg) + 18'(amb_in);
  wire signed [25:0] sum_i = grp_i + ((row_now == 3'h0) ? 26'sh0 : line_i[bcol_now]);
  wire signed [25:0] sum_q = grp_q + ((row_now == 3'h0) ? 26'sh0 : line_q[bcol_now]);
  wire [17:0] sum_a = grp_a + ((row_now == 3'h0) ? 18'h0 : line_a[bcol_now]);

  // Vector sum divided by twice the pixel count once binned; an unbinned pixel is not divided
  wire [2:0] bin_log = 3'(row_exp_reg) + 3'(col_exp_reg);
  wire [2:0] div_sh = bin_log + ((bin_log != 3'h0) ? 3'h1 : 3'h0);
  wire signed [25:0] div_i = sum_i >>> div_sh;
  wire signed [25:0] div_q = sum_q >>> div_sh;
  wire [17:0] avg_a = sum_a >> bin_log;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      acc_i_reg <= 26'sh0;
      acc_q_reg <= 26'sh0;
      acc_a_reg <= 18'h0;
      col_cnt_reg <= 3'h0;
      row_cnt_reg <= 3'h0;
      bcol_reg <= 7'h00;
      first_pend_reg <= 1'b0;
    end else if (in_valid) begin
      acc_i_reg <= grp_i;
      acc_q_reg <= grp_q;
      acc_a_reg <= grp_a;
      first_pend_reg <= ~emit & (in_frame_start | first_pend_reg);
      if (in_row_end) begin
        col_cnt_reg <= 3'h0;
        bcol_reg <= 7'h00;
        row_cnt_reg <= row_last ? 3'h0 : row_now + 3'h1;
      end else begin
        col_cnt_reg <= col_last ? 3'h0 : col_now + 3'h1;
        bcol_reg <= col_last ? bcol_now + 7'h01 : bcol_now;
        row_cnt_reg <= row_now;
      end
    end
  end

  // Partial row sums wait in the line RAM until the row group completes
  always_ff @(posedge clock) begin
    if (in_valid & col_last & ~row_last & (bcol_now < 7'(tdpe_pkg::TDPE_COLS))) begin
      line_i[bcol_now] <= sum_i;
      line_q[bcol_now] <= sum_q;
      line_a[bcol_now] <= sum_a;
    end
  end

  logic bin_valid_reg;
  logic signed [tdpe_pkg::TDPE_XY_W-1:0] bin_x_reg;
  logic signed [tdpe_pkg::TDPE_XY_W-1:0] bin_y_reg;
  logic [11:0] bin_amb_reg;
  logic bin_supp_reg;
  logic bin_first_reg;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bin_valid_reg <= 1'b0;
      bin_x_reg <= '0;
      bin_y_reg <= '0;
      bin_amb_reg <= 12'h000;
      bin_supp_reg <= 1'b0;
      bin_first_reg <= 1'b0;
    end else begin
      bin_valid_reg <= emit;
      if (emit) begin
        bin_x_reg <= div_i[tdpe_pkg::TDPE_XY_W-1:0];
        bin_y_reg <= div_q[tdpe_pkg::TDPE_XY_W-1:0];
        bin_amb_reg <= avg_a[11:0];
        bin_supp_reg <= in_supp_frame;
        bin_first_reg <= in_frame_start | first_pend_reg;
      end
    end
  end

  // ---------------------------------------------------------------
  // Phase and amplitude
  // ---------------------------------------------------------------
  logic [11:0] cord_angle;
  logic [tdpe_pkg::TDPE_CW-1:0] cord_mag;

  tdpe_cordic u_cordic (
    .vec_x(bin_x_reg),
    .vec_y(bin_y_reg),
    .angle(cord_angle),
    .magnitude(cord_mag)
  );

  logic p2_valid_reg;
  logic [11:0] p2_phase_reg;
  logic [11:0] p2_amp_reg;
  logic [11:0] p2_amb_reg;
  logic p2_supp_reg;
  logic p2_first_reg;

  // Amplitude carries the rotator gain as its scale; clipped rather than wrapped
  wire [11:0] amp_sat = (|cord_mag[tdpe_pkg::TDPE_CW-1:12]) ? 12'hfff : cord_mag[11:0];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      p2_valid_reg <= 1'b0;
      p2_phase_reg <= 12'h000;
      p2_amp_reg <= 12'h000;
      p2_amb_reg <= 12'h000;
      p2_supp_reg <= 1'b0;
      p2_first_reg <= 1'b0;
    end else begin
      p2_valid_reg <= bin_valid_reg;
      if (bin_valid_reg) begin
        p2_phase_reg <= cord_angle;
        p2_amp_reg <= amp_sat;
        p2_amb_reg <= bin_amb_reg;
        p2_supp_reg <= bin_supp_reg;
        p2_first_reg <= bin_first_reg;
      end
    end
  end

  // ---------------------------------------------------------------
  // Offset, masking, de-aliasing, packing
  // ---------------------------------------------------------------
  logic [12:0] base_mem [0:tdpe_pkg::TDPE_PIXELS-1];
  logic [12:0] pix_idx_reg;

  wire [11:0] ofs = p2_supp_reg ? supp_ofs_reg : base_ofs_reg;
  wire [11:0] corr_ph = ofs_bypass ? p2_phase_reg : p2_phase_reg + ofs;
  wire sat_hit = p2_amb_reg <= sat_thr_reg;
  wire amp_low = p2_amp_reg < amp_thr_reg;
  wire masked = sat_hit | amp_low;
  wire [11:0] ph12 = masked ? 12'h000 : corr_ph;

  wire [12:0] pix_now = p2_first_reg ? 13'h0000 : pix_idx_reg;
  wire pix_ok = pix_now < 13'(tdpe_pkg::TDPE_PIXELS);
  wire [12:0] base_rd = pix_ok ? base_mem[pix_now] : 13'h0000;

  // Supplementary phase picks which base-frequency wrap the base phase sits in
  wire [15:0] ps_up = 16'({4'h0, corr_ph}) << ratio_reg;
  wire [15:0] wrap_est = ps_up - {4'h0, base_rd[11:0]} + tdpe_pkg::TDPE_ROUND_HALF;
  wire [3:0] kmask = 4'((4'h1 << ratio_reg) - 4'h1);
  wire [3:0] wrap_n = wrap_est[15:12] & kmask;
  wire [15:0] combined = {wrap_n, base_rd[11:0]} << (3'h4 - 3'(ratio_reg));
  wire [15:0] ph16 = (masked | base_rd[12]) ? 16'h0000 : combined;

  wire out_fire = p2_valid_reg & (~combine | (p2_supp_reg & (state_reg == tdpe_pkg::TDPE_ST_BASE_HELD)));
  wire [1:0] fc_now = (out_fire & p2_first_reg) ? fc_reg + 2'h1 : fc_reg;
  wire [3:0] flag4 = {sat_hit, 1'b0, fc_now};
  wire [15:0] phase_word = combine ? ph16 : {flag4, ph12};
  wire [15:0] amp_word = (combine & flags_to_amb) ? {flag4, p2_amp_reg} : {p2_amb_reg[11:8], p2_amp_reg};

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      tdpe_pkg::TDPE_ST_NO_BASE: begin
        if (combine & p2_valid_reg & p2_first_reg & ~p2_supp_reg) begin
          state_next = tdpe_pkg::TDPE_ST_BASE_HELD;
        end
      end
      tdpe_pkg::TDPE_ST_BASE_HELD: begin
        if (!combine) begin
          state_next = tdpe_pkg::TDPE_ST_NO_BASE;
        end
      end
      default: begin
        state_next = tdpe_pkg::TDPE_ST_NO_BASE;
      end
    endcase
  end

  // Base frame is held so the following supplementary frame can be combined
  always_ff @(posedge clock) begin
    if (p2_valid_reg & combine & ~p2_supp_reg & pix_ok) begin
      base_mem[pix_now] <= {masked, corr_ph};
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= tdpe_pkg::TDPE_ST_NO_BASE;
      pix_idx_reg <= 13'h0000;
      fc_reg <= 2'h0;
      out_valid <= 1'b0;
      out_phase_word <= 16'h0000;
      out_amp_word <= 16'h0000;
      out_frame_start <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (p2_valid_reg) begin
        pix_idx_reg <= pix_now + 13'h0001;
      end
      fc_reg <= fc_now;
      out_valid <= out_fire;
      out_frame_start <= out_fire & p2_first_reg;
      if (out_fire) begin
        out_phase_word <= phase_word;
        out_amp_word <= amp_word;
      end
    end
  end

endmodule : tdpe_depth_engine

// ===== tdpe_properties.sv
// Port checker for the depth engine: register bus answers and pixel stream timing.
// Assumes it is bound onto tdpe_depth_engine, one clock, reset arst_n.
`timescale 1ns/1ps
module tdpe_properties (
  input wire logic clock, // Core clock
  input wire logic arst_n, // Reset
  input wire logic hsel, // Select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer
  input wire logic hwrite, // Write
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Ready in
  input wire logic hreadyout, // Ready out
  input wire logic [31:0] hrdata, // Read data
  input wire logic hresp, // Response
  input wire logic in_valid, // Pixel in
  input wire logic out_valid, // Pixel out
  input wire logic [15:0] out_phase_word, // Phase word
  input wire logic [15:0] out_amp_word, // Amplitude word
  input wire logic out_frame_start, // Frame out
  input wire logic timing_generator_run, // Run
  input wire logic alternate_frame_enable // Alternate
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  logic take;
  assign take = hsel && htrans[1] && hready;
  a_ready_high: assert property (hreadyout) else $error("ready low");
  a_resp_okay: assert property (!hresp) else $error("bad response");
  a_ctrl_follow: assert property (take && hwrite && haddr[7:0] == 8'h00 |=> ##2
    {alternate_frame_enable, timing_generator_run} == $past(hwdata[1:0], 2)) else $error("ctrl outputs stale");
  a_rdata_hold: assert property ($changed(hrdata) |-> $past(take && !hwrite)) else $error("rdata moved");
  a_out_latency: assert property (out_valid |-> $past(in_valid, 3)) else $error("output latency");
  a_start_valid: assert property (out_frame_start |-> out_valid) else $error("lone frame start");
  a_phase_hold: assert property ($changed(out_phase_word) |-> out_valid) else $error("phase moved");
  a_amp_hold: assert property ($changed(out_amp_word) |-> out_valid) else $error("amp moved");
endmodule : tdpe_properties

bind tdpe_depth_engine tdpe_properties tdpe_properties_inst (.clock(clock), .arst_n(arst_n), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .in_valid(in_valid), .out_valid(out_valid), .out_phase_word(out_phase_word),
  .out_amp_word(out_amp_word), .out_frame_start(out_frame_start), .timing_generator_run(timing_generator_run),
  .alternate_frame_enable(alternate_frame_enable));

// ===== tdpe_adc_model.sv
// Sensor ADC stand-in: one pixel per call, lines scrambled between frames.
// Assumes one bench process calls send and gap.
`timescale 1ns/1ps
module tdpe_adc_model (
  input wire logic clock, // Core clock
  output logic in_valid, // Pixel strobe
  output logic signed [11:0] in_sample_i, // I sample
  output logic signed [11:0] in_sample_q, // Q sample
  output logic [11:0] in_level, // Level code
  output logic in_frame_start, // Frame marker
  output logic in_row_end, // Row marker
  output logic in_supp_frame // Frequency select
);
  initial begin
    {in_valid, in_sample_i, in_sample_q, in_level, in_frame_start, in_row_end, in_supp_frame} = '0;
  end
  task automatic send(input logic signed [11:0] i, input logic signed [11:0] q, input logic [11:0] lv,
    input logic fs, input logic re, input logic sp);
    @(posedge clock);
    {in_valid, in_sample_i, in_sample_q, in_level, in_frame_start, in_row_end, in_supp_frame} <= {1'b1, i, q, lv, fs, re, sp};
  endtask : send
  // Inverted data so a stale sample never looks valid
  task automatic gap();
    @(posedge clock);
    {in_valid, in_sample_i, in_sample_q, in_level, in_frame_start, in_row_end} <= {1'b0, ~in_sample_i, ~in_sample_q,
      ~in_level, 2'b00};
    repeat (6) @(posedge clock);
  endtask : gap
endmodule : tdpe_adc_model

// ===== tb_top.sv
// Bench: AHB-Lite register tasks, ADC stand-in, queued pixel expectations.
// Assumes one slave, so hready is the slave's own hreadyout.
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
  typedef struct packed {logic [15:0] ph; logic [15:0] am; logic w; logic fs;} tdpe_exp_t;
  logic clock, arst_n, hsel, hwrite, hready, hreadyout, hresp, out_valid, out_frame_start, tg_run, alt_en;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic in_valid, in_frame_start, in_row_end, in_supp_frame;
  logic signed [11:0] in_sample_i, in_sample_q;
  logic [11:0] in_level;
  logic [15:0] out_phase_word, out_amp_word;
  logic [31:0] seed = 32'hecca;
  logic [1:0] fc = 2'h0;
  logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h40};
  logic [31:0] rv [7] = '{32'h0, 32'h200, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  int err_total = 0;
  int samples_checked = 0;
  tdpe_exp_t exq[$];
  tdpe_exp_t e;
  assign hready = hreadyout;
  tdpe_depth_engine tdpe_depth_engine_inst (.clock(clock), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .in_valid(in_valid), .in_sample_i(in_sample_i), .in_sample_q(in_sample_q),
    .in_level(in_level), .in_frame_start(in_frame_start), .in_row_end(in_row_end), .in_supp_frame(in_supp_frame),
    .out_valid(out_valid), .out_phase_word(out_phase_word), .out_amp_word(out_amp_word),
    .out_frame_start(out_frame_start), .timing_generator_run(tg_run), .alternate_frame_enable(alt_en));
  tdpe_adc_model tdpe_adc_model_inst (.clock(clock), .in_valid(in_valid), .in_sample_i(in_sample_i),
    .in_sample_q(in_sample_q), .in_level(in_level), .in_frame_start(in_frame_start), .in_row_end(in_row_end),
    .in_supp_frame(in_supp_frame));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  function automatic logic near(input logic [15:0] a, input logic [15:0] b, input logic [15:0] t);
    logic [15:0] d;
    d = a - b + t;
    return d <= 2 * t;
  endfunction : near
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic summarize();
    if (err_total == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (hready !== 1'b1) begin
      err_total++;
      summarize();
    end
  endtask : wait_rdy
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clock);
    {hsel, htrans, haddr, hwrite} <= {1'b1, 2'b10, 24'h0, a, w};
    wait_rdy();
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
    wait_rdy();
    r = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    `CHK(r, x)
  endtask : rd
  task automatic px(input int q, input logic [11:0] lv, input logic fs, input logic re);
    tdpe_adc_model_inst.send(q == 0 ? 12'sd500 : q == 2 ? -12'sd500 : 12'sd0,
      q == 1 ? 12'sd500 : q == 3 ? -12'sd500 : 12'sd0, lv, fs, re, 1'b0);
  endtask : px
  // Saturation threshold stays at its zero default, so only ambient 0 saturates
  task automatic ex(input int q, input logic [11:0] lv, input logic fs, input int amp, input logic [11:0] ofs,
    input logic [11:0] thr);
    logic [11:0] amb, ph;
    logic sat;
    amb = 12'hfff - lv;
    sat = amb == 12'h000;
    fc = fs ? fc + 2'h1 : fc;
    ph = (sat || amp < thr) ? 12'h000 : 12'(q * 1024) + ofs;
    exq.push_back('{ph: {sat, 1'b0, fc, ph}, am: {amb[11:8], 12'(amp)}, w: 1'b0, fs: fs});
  endtask : ex
  task automatic frame(input int amp, input logic [11:0] ofs, input logic [11:0] thr);
    int q;
    logic [11:0] lv;
    for (int k = 0; k < 8; k++) begin
      q = xs() % 4;
      lv = k == 7 ? 12'hfff : 12'(xs()) & 12'hffe;
      px(q, lv, k == 0, k == 7);
      ex(q, lv, k == 0, amp, ofs, thr);
    end
    tdpe_adc_model_inst.gap();
  endtask : frame
  always @(posedge clock) begin
    if (out_valid === 1'b1 && exq.size() == 0) begin
      `CHK(out_valid, 1'b0)
    end else if (out_valid === 1'b1) begin
      e = exq.pop_front();
      `CHK(out_frame_start, e.fs)
      `CHK(near(out_phase_word << (e.w ? 0 : 4), e.ph << (e.w ? 0 : 4), e.w ? 16'd16 : 16'd48), 1'b1)
      `CHK(out_phase_word[15:12], e.ph[15:12])
      `CHK(out_amp_word[15:12], e.am[15:12])
      `CHK(near(out_amp_word << 4, e.am << 4, 16'd80), 1'b1)
    end
  end
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, arst_n} = '0;
    hsize = 3'h2;
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    for (int k = 0; k < 7; k++) rd(ra[k], rv[k]);
    wr(8'h00, 32'h1);
    wr(8'h10, 32'hf80);
    rd(8'h10, 32'hf80);
    frame(823, 12'hf80, 12'h000);
    wr(8'h08, 32'h1);
    wr(8'h0c, 32'h400);
    wr(8'h00, 32'h29);
    frame(1647, 12'h000, 12'h400);
    wr(8'h00, 32'h21);
    frame(823, 12'h000, 12'h400);
    wr(8'h04, 32'h211);
    wr(8'h0c, 32'h200);
    for (int r = 0; r < 2; r++) for (int c = 0; c < 4; c++) px(c / 2, 12'h100, r == 0 && c == 0, c == 3);
    ex(0, 12'h100, 1'b1, 411, 12'h000, 12'h200);
    ex(1, 12'h100, 1'b0, 411, 12'h000, 12'h200);
    tdpe_adc_model_inst.gap();
    wr(8'h00, 32'h0);
    wr(8'h00, 32'h2);
    wr(8'h04, 32'h200);
    wr(8'h10, 32'h0);
    wr(8'h0c, 32'h0);
    wr(8'h00, 32'h16);
    wr(8'h00, 32'h17);
    px(1, 12'h100, 1'b1, 1'b1);
    tdpe_adc_model_inst.gap();
    tdpe_adc_model_inst.send(12'sd462, 12'sd191, 12'h100, 1'b1, 1'b1, 1'b1);
    fc = fc + 2'h1;
    exq.push_back('{ph: 16'h1000, am: {2'b00, fc, 12'd823}, w: 1'b1, fs: 1'b1});
    tdpe_adc_model_inst.gap();
    rd(8'h14, 32'h9);
    `CHK(exq.size(), 0)
    summarize();
  end
endmodule : tb_top
